// file: hdl/lcd_segment_device.sv
// Design decisions made here: the serial receiver, the register store and the backplane drive.
`timescale 1ns/1ps
`default_nettype none
module lcd_segment_device #(
  parameter logic [6:0] SLAVE_ADDR = lcd_link_pkg::SLAVE_ADDR_DEF,
  parameter int SLOT_CYC = lcd_link_pkg::SLOT_CYC
) (
  input wire logic REF_CLK_I,
  input wire logic RESET_N_I,
  input wire logic [lcd_link_pkg::SUB_W-1:0] SUBADDR_I,
  lcd_link_if.device LINK,
  output logic [lcd_link_pkg::SEG_N-1:0] SEGMENT_O,
  output logic BACKPLANE_FIRST_O,
  output logic BACKPLANE_SECOND_O
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_BITS,
    ST_ACK_SETUP,
    ST_ACK,
    ST_IGNORE
  } rx_state_t;

  typedef logic [lcd_link_pkg::BYTE_W-1:0] byte_t;

  typedef struct packed {
    rx_state_t st;
    byte_t shift;
    logic [2:0] bit_cnt;
    logic [1:0] byte_no;
    logic ack;
    byte_t ctrl;
    byte_t [lcd_link_pkg::STORE_N-1:0] store;
    logic scl_d;
    logic sda_d;
    logic sda_oe_n;
    logic [lcd_link_pkg::DIV_W-1:0] div;
    logic slot;
    logic [lcd_link_pkg::SEG_N-1:0] seg;
    logic bp_first;
    logic bp_second;
  } dev_t;

  localparam logic [lcd_link_pkg::DIV_W-1:0] DIV_LAST =
    lcd_link_pkg::DIV_W'(SLOT_CYC - 1);
  localparam logic [2:0] CNT_LAST = 3'(lcd_link_pkg::BIT_LAST);
  localparam logic [1:0] NO_ADDR = 2'h0;
  localparam logic [1:0] NO_CTRL = 2'h1;
  localparam logic [1:0] NO_DATA = 2'h2;

  dev_t r;
  dev_t next_r;
  logic [lcd_link_pkg::SUB_W+1:0] sync_q;
  logic scl;
  logic sda;
  logic [lcd_link_pkg::SUB_W-1:0] sub;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic mode;
  logic sel;
  logic hit;
  byte_t byte_in;
  logic [lcd_link_pkg::PTR_W-1:0] ptr;
  logic [lcd_link_pkg::PTR_W-1:0] step;

  if (SLOT_CYC < 1 || SLOT_CYC > (1 << lcd_link_pkg::DIV_W)) begin : g_bad
    $error("lcd_segment_device: slot count out of range");
  end

  // bus lines and the subaddress straps come from outside
  lcd_sync2 #(.W(lcd_link_pkg::SUB_W + 2)) u_sync (
    .clk_i(REF_CLK_I),
    .reset_n_i(RESET_N_I),
    .d_i({LINK.scl, LINK.sda, SUBADDR_I}),
    .q_o(sync_q)
  );

  ////////////////////////////////////////////////////////////////////
  // line events, all from the synchronised copies
  always_comb begin
    scl = sync_q[lcd_link_pkg::SUB_W + 1];
    sda = sync_q[lcd_link_pkg::SUB_W];
    sub = sync_q[lcd_link_pkg::SUB_W-1:0];
    scl_rise = scl & ~r.scl_d;
    scl_fall = ~scl & r.scl_d;
    start = scl & r.scl_d & r.sda_d & ~sda;
    stop = scl & r.scl_d & ~r.sda_d & sda;
    // msb arrives first, so shift towards the top
    byte_in = {r.shift[lcd_link_pkg::BIT_LAST-1:0], sda};
    mode = r.ctrl[lcd_link_pkg::MODE_BIT];
    ptr = r.ctrl[lcd_link_pkg::PTR_W-1:0];
    step = mode ? lcd_link_pkg::STEP_DUPLEX
                : lcd_link_pkg::STEP_DIRECT;
    // duplex borrows the top subaddress pin, so only two bits count
    if (mode) begin
      hit = ptr[lcd_link_pkg::SUB_LSB +: lcd_link_pkg::SUB_DUPLEX_W] ==
            sub[lcd_link_pkg::SUB_DUPLEX_W-1:0];
    end else begin
      hit = ptr[lcd_link_pkg::SUB_LSB +: lcd_link_pkg::SUB_W] == sub;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // serial receiver and register loading
  always_comb begin
    next_r = r;
    next_r.scl_d = scl;
    next_r.sda_d = sda;
    unique case (r.st)
      ST_IDLE: next_r.st = ST_IDLE;
      ST_IGNORE: next_r.st = ST_IGNORE;
      ST_BITS: begin
        // one bit taken per rising clock
        if (scl_rise) begin
          next_r.shift = byte_in;
          next_r.bit_cnt = r.bit_cnt + 1'b1;
          if (r.bit_cnt == CNT_LAST) begin
            next_r.st = ST_ACK_SETUP;
            next_r.ack = 1'b0;
            // byte number saturates: no limit on data bytes
            if (r.byte_no != NO_DATA) begin
              next_r.byte_no = r.byte_no + 1'b1;
            end
            unique case (r.byte_no)
              NO_ADDR: begin
                // write direction only; reads are not served
                if (byte_in[lcd_link_pkg::BIT_LAST:1] == SLAVE_ADDR &&
                    !byte_in[0]) begin
                  next_r.ack = 1'b1;
                end else begin
                  next_r.st = ST_IGNORE;
                end
              end
              NO_CTRL: begin
                // every addressed device keeps the same control copy
                next_r.ctrl = byte_in;
                next_r.ack = 1'b1;
              end
              default: begin
                if (hit) begin
                  next_r.store[ptr[lcd_link_pkg::SEL_W-1:0]] =
                    byte_in;
                  next_r.ack = 1'b1;
                end
                // pointer moves in every device to stay in step
                next_r.ctrl[lcd_link_pkg::PTR_W-1:0] = ptr + step;
              end
            endcase
          end
        end
      end
      ST_ACK_SETUP: begin
        // drive only after the eighth pulse has ended
        if (scl_fall) begin
          next_r.sda_oe_n = ~r.ack;
          next_r.st = ST_ACK;
        end
      end
      ST_ACK: begin
        // held low across the whole acknowledge pulse
        if (scl_fall) begin
          next_r.sda_oe_n = 1'b1;
          next_r.bit_cnt = '0;
          next_r.st = ST_BITS;
        end
      end
      default: next_r.st = ST_IDLE;
    endcase
    // start and stop override any byte in flight
    if (start) begin
      next_r.st = ST_BITS;
      next_r.bit_cnt = '0;
      next_r.byte_no = NO_ADDR;
      next_r.sda_oe_n = 1'b1;
    end else if (stop) begin
      next_r.st = ST_IDLE;
      next_r.sda_oe_n = 1'b1;
    end

    //////////////////////////////////////////////////////////////////
    // display side: slot timer stands in for the local oscillator
    if (r.div == DIV_LAST) begin
      next_r.div = '0;
      next_r.slot = ~r.slot;
    end else begin
      next_r.div = r.div + 1'b1;
    end
    // duplex alternates banks per slot, direct follows the page bit
    sel = mode ? r.slot : r.ctrl[lcd_link_pkg::BANK_BIT];
    for (int i = 0; i < lcd_link_pkg::GROUP_N; i++) begin
      next_r.seg[i*lcd_link_pkg::BYTE_W +: lcd_link_pkg::BYTE_W] =
        r.store[{i[1:0], sel}];
    end
    // first backplane active while even bytes are shown in duplex, and always active in direct
    next_r.bp_first = mode ? ~r.slot : 1'b1;
    next_r.bp_second = mode & r.slot;
  end

  // reset clears storage, control and the receiver
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      r <= '0;
      r.sda_oe_n <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs straight from the state register
  assign SEGMENT_O = r.seg;
  assign BACKPLANE_FIRST_O = r.bp_first;
  assign BACKPLANE_SECOND_O = r.bp_second;
  assign LINK.dev_sda_oe_n = r.sda_oe_n;
endmodule
`default_nettype wire

// file: hdl/lcd_link_pkg.sv
`default_nettype none
package lcd_link_pkg;
  // byte and register geometry
  localparam int BYTE_W = 8;
  localparam int STORE_N = 8;
  localparam int GROUP_N = 4;
  localparam int SEG_N = 32;
  localparam int BIT_LAST = BYTE_W - 1;
  // control byte layout
  localparam int MODE_BIT = 7;
  localparam int BANK_BIT = 6;
  localparam int PTR_W = 6;
  localparam int SEL_W = 3;
  localparam int SUB_LSB = 3;
  localparam int SUB_W = 3;
  localparam int SUB_DUPLEX_W = 2;
  localparam logic [PTR_W-1:0] STEP_DIRECT = 6'h02;
  localparam logic [PTR_W-1:0] STEP_DUPLEX = 6'h01;
  // serial address, value is arbitrary
  localparam logic [6:0] SLAVE_ADDR_DEF = 7'h3a;
  // timing at the reference clock
  localparam int REF_NS = 40;
  localparam int STEP_NS = 160;
  localparam int STEP_CYC = (STEP_NS + REF_NS - 1) / REF_NS;
  localparam int STEP_MIN = 3;
  localparam int STEP_W = 16;
  localparam int SLOT_NS = 4000;
  localparam int SLOT_CYC = SLOT_NS / REF_NS;
  localparam int DIV_W = 16;
  // controller registers on the apb side
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_TX = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_STEP = 8'h08;
  localparam int TX_START = 8;
  localparam int TX_STOP = 9;
  localparam int TX_STOP_ONLY = 10;
  localparam int STAT_BUSY = 0;
  localparam int STAT_NACK = 1;
  localparam int STAT_HOLD = 2;
endpackage
`default_nettype wire

// file: hdl/lcd_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface lcd_link_if;
  logic scl;
  logic mst_sda_oe_n;
  logic dev_sda_oe_n;
  logic sda;
  // open drain: pull-up wins unless one end pulls low
  assign sda = mst_sda_oe_n & dev_sda_oe_n;
  modport master(output scl, output mst_sda_oe_n, input sda);
  modport device(input scl, input sda, output dev_sda_oe_n);
endinterface
`default_nettype wire

// file: hdl/lcd_sync2.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_sync2 #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } sync_t;
  sync_t r;
  sync_t next_r;

  if (W < 1) begin : g_bad_w
    $error("lcd_sync2: width must be at least one");
  end

  // first stage is read only by the second
  always_comb begin
    next_r.meta = d_i;
    next_r.q = r.meta;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign q_o = r.q;
endmodule
`default_nettype wire

// file: hdl/lcd_serial_master.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_serial_master #(
  parameter int STEP_CYC = lcd_link_pkg::STEP_CYC
) (
  input wire logic REF_CLK_I,
  input wire logic RESET_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [lcd_link_pkg::ADDR_W-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  lcd_link_if.master LINK
);
  typedef enum logic [3:0] {
    M_IDLE, M_HOLD, M_START_A, M_START_B, M_START_C,
    M_BIT_LOW, M_BIT_DATA, M_BIT_HIGH,
    M_STOP_A, M_STOP_B, M_STOP_C
  } mst_state_t;
  typedef struct packed {
    mst_state_t st;
    logic [lcd_link_pkg::STEP_W-1:0] cnt;
    logic [lcd_link_pkg::STEP_W-1:0] step;
    logic [lcd_link_pkg::BYTE_W-1:0] tx;
    logic stop_f;
    logic [3:0] bit_idx;
    logic scl;
    logic sda_oe_n;
    logic nack;
    logic [31:0] prdata;
    logic pready;
  } mst_t;
  localparam logic [lcd_link_pkg::STEP_W-1:0] STEP_RST =
    lcd_link_pkg::STEP_W'(STEP_CYC);
  localparam logic [lcd_link_pkg::STEP_W-1:0] STEP_LOW =
    lcd_link_pkg::STEP_W'(lcd_link_pkg::STEP_MIN);

  mst_t r;
  mst_t next_r;
  logic sda_s;
  logic tick;
  logic busy;
  logic wr;
  logic [lcd_link_pkg::STEP_W-1:0] reload;

  if (STEP_CYC < lcd_link_pkg::STEP_MIN ||
      STEP_CYC >= (1 << lcd_link_pkg::STEP_W)) begin : g_bad
    $error("lcd_serial_master: step count out of range");
  end

  lcd_sync2 #(.W(1)) u_sync (
    .clk_i(REF_CLK_I),
    .reset_n_i(RESET_N_I),
    .d_i(LINK.sda),
    .q_o(sda_s)
  );

  ////////////////////////////////////////////////////////////////////
  // apb slave and line sequencer
  always_comb begin
    next_r = r;
    next_r.pready = 1'b1;
    tick = (r.cnt == '0);
    busy = (r.st != M_IDLE) && (r.st != M_HOLD);
    wr = PSEL_I & PENABLE_I & PWRITE_I;
    reload = r.step - 1'b1;
    // read data latched in setup, so no wait states
    if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
      next_r.prdata = '0;
      unique case (PADDR_I)
        lcd_link_pkg::ADDR_TX: next_r.prdata[lcd_link_pkg::BIT_LAST:0] = r.tx;
        lcd_link_pkg::ADDR_STAT: begin
          next_r.prdata[lcd_link_pkg::STAT_BUSY] = busy;
          next_r.prdata[lcd_link_pkg::STAT_NACK] = r.nack;
          next_r.prdata[lcd_link_pkg::STAT_HOLD] = (r.st == M_HOLD);
        end
        lcd_link_pkg::ADDR_STEP:
          next_r.prdata[lcd_link_pkg::STEP_W-1:0] = r.step;
        default: next_r.prdata = '0;
      endcase
    end
    // step writes below the sync latency are dropped
    if (wr && PADDR_I == lcd_link_pkg::ADDR_STEP && !busy &&
        PWDATA_I[lcd_link_pkg::STEP_W-1:0] >= STEP_LOW) begin
      next_r.step = PWDATA_I[lcd_link_pkg::STEP_W-1:0];
    end
    // a command while busy is ignored
    if (wr && PADDR_I == lcd_link_pkg::ADDR_TX && !busy) begin
      next_r.tx = PWDATA_I[lcd_link_pkg::BIT_LAST:0];
      next_r.stop_f = PWDATA_I[lcd_link_pkg::TX_STOP];
      next_r.bit_idx = '0;
      next_r.cnt = reload;
      if (PWDATA_I[lcd_link_pkg::TX_STOP_ONLY] && r.st == M_HOLD) begin
        next_r.st = M_STOP_A;
      end else if (PWDATA_I[lcd_link_pkg::TX_START] || r.st == M_IDLE) begin
        next_r.sda_oe_n = 1'b1;
        next_r.st = M_START_A;
      end else begin
        next_r.st = M_BIT_LOW;
      end
    end else if (busy) begin
      next_r.cnt = tick ? reload : r.cnt - 1'b1;
      if (tick) begin
        unique case (r.st)
          M_START_A: begin
            next_r.scl = 1'b1;
            next_r.st = M_START_B;
          end
          M_START_B: begin
            // wait for both lines high before the start
            if (sda_s && r.scl) begin
              next_r.sda_oe_n = 1'b0;
              next_r.st = M_START_C;
            end
          end
          M_START_C: begin
            next_r.scl = 1'b0;
            next_r.st = M_BIT_LOW;
          end
          M_BIT_LOW: begin
            // data moves only while the clock is low
            if (r.bit_idx == 4'(lcd_link_pkg::BYTE_W)) begin
              next_r.sda_oe_n = 1'b1;
            end else begin
              next_r.sda_oe_n = r.tx[lcd_link_pkg::BIT_LAST];
            end
            next_r.st = M_BIT_DATA;
          end
          M_BIT_DATA: begin
            next_r.scl = 1'b1;
            next_r.st = M_BIT_HIGH;
          end
          M_BIT_HIGH: begin
            next_r.scl = 1'b0;
            next_r.bit_idx = r.bit_idx + 1'b1;
            if (r.bit_idx == 4'(lcd_link_pkg::BYTE_W)) begin
              next_r.nack = sda_s;
              next_r.st = r.stop_f ? M_STOP_A : M_HOLD;
            end else begin
              next_r.tx = {r.tx[lcd_link_pkg::BIT_LAST-1:0], 1'b0};
              next_r.st = M_BIT_LOW;
            end
          end
          M_STOP_A: begin
            next_r.sda_oe_n = 1'b0;
            next_r.st = M_STOP_B;
          end
          M_STOP_B: begin
            next_r.scl = 1'b1;
            next_r.st = M_STOP_C;
          end
          M_STOP_C: begin
            next_r.sda_oe_n = 1'b1;
            next_r.st = M_IDLE;
          end
          default: next_r.st = M_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      r <= '0;
      r.step <= STEP_RST;
      r.scl <= 1'b1;
      r.sda_oe_n <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign PRDATA_O = r.prdata;
  assign PREADY_O = r.pready;
  assign LINK.scl = r.scl;
  assign LINK.mst_sda_oe_n = r.sda_oe_n;
endmodule
`default_nettype wire

// file: verification/lcd_link_chk.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_link_chk (
  input wire logic REF_CLK_I,
  input wire logic RESET_N_I,
  input wire logic scl,
  input wire logic mst_sda_oe_n,
  input wire logic dev_sda_oe_n,
  input wire logic sda
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RESET_N_I);
  ////////////////////////////////////////////////////////////////////////
  // bit position inside the current byte, restarted by a start condition
  logic prev_scl;
  logic [3:0] bitn;
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      prev_scl <= 1'b1;
      bitn <= 4'h0;
    end else begin
      prev_scl <= scl;
      if (scl && prev_scl && $fell(sda)) begin
        bitn <= 4'h0;
      end else if (scl && !prev_scl) begin
        bitn <= (bitn == 4'h8) ? 4'h0 : bitn + 4'h1;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // every bench transfer targets this device, so each byte is acked
  a_ack_whole: assert property ($fell(dev_sda_oe_n) |->
    !dev_sda_oe_n throughout (##[1:40] $rose(scl) ##[1:40] $fell(scl)))
    else $error("device released data inside its acknowledge pulse");
  a_ack_sampled: assert property ($rose(scl) && bitn == 4'h8 |->
    !sda [*4]) else $error("acknowledge pulse not held low");
  a_ack_release: assert property ($rose(scl) && bitn == 4'h8 |->
    mst_sda_oe_n [*4]) else $error("master drove data during acknowledge");
  a_data_quiet: assert property ($rose(scl) && bitn < 4'h8 |->
    dev_sda_oe_n) else $error("device pulled data during a data bit");
  // position one is where a stop or a repeated start falls
  a_mst_bit_stable: assert property (
    $changed(mst_sda_oe_n) && bitn > 4'h1 |-> !scl)
    else $error("master data changed while clock high mid byte");
  a_scl_high: assert property ($rose(scl) |-> scl [*4])
    else $error("clock high phase too short");
  a_stop_quiet: assert property ($rose(sda) && scl && $past(scl) |->
    dev_sda_oe_n [*8]) else $error("device active after stop");
  a_start_seen: assert property ($fell(sda) && scl |->
    $past(scl) && dev_sda_oe_n) else $error("data fell while clock high");
endmodule
`default_nettype wire

// file: verification/lcd_segment_map_i2c_rx_bench.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_segment_map_i2c_rx_bench;
  logic clk, rst_n, psel, penable, pwrite, pready, bp_first, bp_second;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, seg;
  int n_mismatch, comparisons;
  ////////////////////////////////////////////////////////////////////////
  lcd_link_if link();
  lcd_serial_master i_lcd_serial_master (.REF_CLK_I(clk), .RESET_N_I(rst_n),
    .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .LINK(link));
  // short slot keeps the duplex checks fast; subaddress 5 tests compare
  lcd_segment_device #(.SLOT_CYC(8)) i_lcd_segment_device (.REF_CLK_I(clk),
    .RESET_N_I(rst_n), .SUBADDR_I(3'h5), .LINK(link), .SEGMENT_O(seg),
    .BACKPLANE_FIRST_O(bp_first), .BACKPLANE_SECOND_O(bp_second));
  lcd_link_chk i_lcd_link_chk (.REF_CLK_I(clk), .RESET_N_I(rst_n),
    .scl(link.scl),
    .mst_sda_oe_n(link.mst_sda_oe_n), .dev_sda_oe_n(link.dev_sda_oe_n),
    .sda(link.sda));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task summarize;
    $display("counts: %0d compared, %0d failed", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task hang;
    n_mismatch++;
    $display("wait limit reached at %0t", $time);
    summarize;
  endtask
  // one apb transfer; pready is waited for, never assumed
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) hang;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // poll until the controller is no longer busy (idle or hold); every byte here must be acked
  task settle;
    int k;
    k = 0;
    do begin
      apb(1'b0, lcd_link_pkg::ADDR_STAT, 32'h0000_0000);
      k++;
    end while (rd[lcd_link_pkg::STAT_BUSY] !== 1'b0 && k < 500);
    if (k >= 500) hang;
    chk({31'h0, rd[lcd_link_pkg::STAT_NACK]}, 32'h0000_0000);
  endtask
  // one byte on the link, then wait for it to finish
  task send(input logic [7:0] b, input logic st, input logic sp);
    apb(1'b1, lcd_link_pkg::ADDR_TX, {22'h0, sp, st, b});
    settle;
  endtask
  task xfer(input logic [7:0] ctl, input logic [63:0] d, input int n);
    send({lcd_link_pkg::SLAVE_ADDR_DEF, 1'b0}, 1'b1, 1'b0);
    send(ctl, 1'b0, n == 0);
    for (int i = 0; i < n; i++) begin
      send(d[8*i +: 8], 1'b0, i == n - 1);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  task t_rst;
    rst_n <= 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    chk(seg, 32'h0000_0000);
    chk({30'h0, bp_first, bp_second}, 32'h0000_0002);
    apb(1'b0, lcd_link_pkg::ADDR_STEP, 32'h0000_0000);
    chk(rd, 32'h0000_0004);
    apb(1'b0, 8'h0c, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    $display("reset test done");
  endtask
  // direct drive: pointer 0x28 sits in subaddress 5, steps by two
  task t_direct;
    xfer(8'h28, 64'h0000_0000_4433_2211, 4);
    chk(seg, 32'h4433_2211);
    xfer(8'h69, 64'h0000_0000_8483_8281, 4);
    chk(seg, 32'h8483_8281);
    xfer(8'h28, 64'h0000_0000_0000_0000, 0);
    chk(seg, 32'h4433_2211);
    chk({30'h0, bp_first, bp_second}, 32'h0000_0002);
    $display("direct test done");
  endtask
  // step register limits, restart from hold and a stop-only command
  task t_restart;
    apb(1'b1, lcd_link_pkg::ADDR_STEP, 32'h0000_0002);
    apb(1'b0, lcd_link_pkg::ADDR_STEP, 32'h0000_0000);
    chk(rd, 32'h0000_0004);
    apb(1'b1, lcd_link_pkg::ADDR_STEP, 32'h0000_0005);
    apb(1'b0, lcd_link_pkg::ADDR_STEP, 32'h0000_0000);
    chk(rd, 32'h0000_0005);
    send({lcd_link_pkg::SLAVE_ADDR_DEF, 1'b0}, 1'b1, 1'b0);
    send(8'h28, 1'b0, 1'b0);
    send(8'h5a, 1'b0, 1'b0);
    apb(1'b0, lcd_link_pkg::ADDR_STAT, 32'h0000_0000);
    chk(rd, 32'h0000_0004);
    // repeated start straight from the hold state
    send({lcd_link_pkg::SLAVE_ADDR_DEF, 1'b0}, 1'b1, 1'b0);
    send(8'h2c, 1'b0, 1'b0);
    send(8'hc3, 1'b0, 1'b0);
    apb(1'b1, lcd_link_pkg::ADDR_TX, 32'h0000_0400);
    settle;
    chk(rd, 32'h0000_0000);
    chk(seg, 32'h44c3_225a);
    $display("restart test done");
  endtask
  task plane(input logic first, input logic [31:0] exp);
    int k;
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while ({bp_first, bp_second} !== {first, ~first} && k < 100);
    if (k >= 100) hang;
    // planes and segments leave the same slot, so compare at once
    chk(seg, exp);
  endtask
  // duplex with bank bit set: bank must not matter, pointer steps by one
  task t_duplex;
    xfer(8'hc8, 64'hf7e6_d5c4_b3a2_9180, 8);
    plane(1'b1, 32'he6c4_a280);
    plane(1'b0, 32'hf7d5_b391);
    $display("duplex test done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    n_mismatch = 0;
    comparisons = 0;
    t_rst;
    t_direct;
    t_restart;
    t_duplex;
    t_rst;
    summarize;
  end
endmodule
`default_nettype wire
